//--- verilog/flash_pin_defines.svh
`ifndef FLASH_PIN_DEFINES_SVH
`define FLASH_PIN_DEFINES_SVH

// pin levels and reset values
`define CS_IDLE_LEVEL   1'h1
`define SCK_IDLE_LEVEL  1'h0
`define IO_IDLE_LEVELS  4'h0

// byte framing
`define BYTE_BITS       4'h8
`define RX_LAST_BIT     3'h7
`define RX_FIRST_BIT    3'h0
`define TX_EMPTY_BITS   4'h0
`define TX_IDLE_BYTE    8'hFF

// bits launched per falling clock edge
`define LANE_BITS_ONE   4'h1
`define LANE_BITS_TWO   4'h2
`define LANE_BITS_FOUR  4'h4

// output enable masks per lane mode
`define OE_MASK_NONE    4'h0
`define OE_MASK_SINGLE  4'h2
`define OE_MASK_DUAL    4'h3
`define OE_MASK_QUAD    4'hF

// receive fifo shape
`define RX_FIFO_WIDTH   8
`define RX_FIFO_DEPTH   8

`endif

//--- verilog/flash_pin_pkg.sv
package flash_pin_pkg;

	typedef enum logic [1:0] {
		LANE_SINGLE = 2'h0,
		LANE_DUAL   = 2'h1,
		LANE_QUAD   = 2'h2
	} lane_mode_t;

	typedef enum logic [1:0] {
		ST_STANDBY = 2'h0,
		ST_ACTIVE  = 2'h1,
		ST_FINISH  = 2'h2
	} frame_state_t;

endpackage

//--- verilog/rx_byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module rx_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,       // system clock
	input  wire logic             rst,       // synchronous reset, high
	input  wire logic             in_valid,  // write request
	output logic                  in_ready,  // room in the store
	input  wire logic [WIDTH-1:0] in_data,   // write data
	output logic                  out_valid, // output register holds a word
	input  wire logic             out_ready, // consumer takes the word
	output logic      [WIDTH-1:0] out_data   // registered read data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready       = (count != (AW+1)'(DEPTH));
		push           = in_valid && in_ready;
		pop            = (count != '0) && (!out_valid || out_ready);
		next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count     = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
		next_out_data  = pop ? mem[rd_ptr] : out_data;
		next_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			out_valid <= next_out_valid;
			out_data  <= next_out_data;
		end
	end

endmodule

`default_nettype wire

//--- verilog/flash_serial_pin_front_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_defines.svh"

module flash_serial_pin_front_end (
	input  wire logic       sys_clk_in,          // 25 MHz system clock
	input  wire logic       rst_in,              // synchronous reset, high
	input  wire logic       sck_in,              // serial clock pin
	input  wire logic       cs_n_in,             // chip select pin, low active
	input  wire logic [3:0] io_in,               // lane pin levels
	output logic      [3:0] io_out,              // lane drive values
	output logic      [3:0] io_oe_out,           // lane drive enables
	input  wire logic       quad_lane_enable_in, // quad lane enable bit
	input  wire logic [1:0] lane_mode_in,        // read lane mode
	input  wire logic       read_phase_in,       // read data phase active
	input  wire logic       op_busy_in,          // self-timed operation running
	input  wire logic [7:0] tx_data_in,          // read byte to send
	input  wire logic       tx_valid_in,         // read byte available
	output logic            tx_ready_out,        // read byte taken
	output logic      [7:0] rx_data_out,         // received byte
	output logic            rx_valid_out,        // received byte available
	input  wire logic       rx_ready_in,         // received byte taken
	output logic            rx_overrun_out,      // byte lost, fifo full
	output logic            frame_start_out,     // operation start pulse
	output logic            frame_end_out,       // operation end pulse
	output logic            selected_out,        // device selected
	output logic            standby_out          // device in standby
);

	// pin synchronisers
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	logic       sck_d;
	logic       cs_n_d;
	logic       sck_s;
	logic       cs_n_s;
	logic [3:0] io_s;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_fall;
	logic       cs_rise;
	logic       selected;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sync_a <= {`SCK_IDLE_LEVEL, `CS_IDLE_LEVEL, `IO_IDLE_LEVELS};
			sync_b <= {`SCK_IDLE_LEVEL, `CS_IDLE_LEVEL, `IO_IDLE_LEVELS};
			sck_d  <= `SCK_IDLE_LEVEL;
			cs_n_d <= `CS_IDLE_LEVEL;
		end else begin
			sync_a <= {sck_in, cs_n_in, io_in};
			sync_b <= sync_a;
			sck_d  <= sck_s;
			cs_n_d <= cs_n_s;
		end
	end

	always_comb begin
		sck_s    = sync_b[5];
		cs_n_s   = sync_b[4];
		io_s     = sync_b[3:0];
		sck_rise = sck_s && !sck_d;
		sck_fall = !sck_s && sck_d;
		cs_fall  = !cs_n_s && cs_n_d;
		cs_rise  = cs_n_s && !cs_n_d;
		selected = !cs_n_s;
	end

	// framing and standby
	flash_pin_pkg::frame_state_t state;
	flash_pin_pkg::frame_state_t next_state;
	logic next_frame_start;
	logic next_frame_end;
	logic next_standby;

	always_comb begin
		next_state       = state;
		next_frame_start = cs_fall;
		next_frame_end   = cs_rise;
		unique case (state)
			flash_pin_pkg::ST_STANDBY: begin
				if (cs_fall) begin
					next_state = flash_pin_pkg::ST_ACTIVE;
				end
			end
			flash_pin_pkg::ST_ACTIVE: begin
				if (cs_rise) begin
					next_state = op_busy_in ? flash_pin_pkg::ST_FINISH : flash_pin_pkg::ST_STANDBY;
				end
			end
			flash_pin_pkg::ST_FINISH: begin
				if (cs_fall) begin
					next_state = flash_pin_pkg::ST_ACTIVE;
				end else if (!op_busy_in) begin
					next_state = flash_pin_pkg::ST_STANDBY;
				end
			end
			default: begin
				next_state = flash_pin_pkg::ST_STANDBY;
			end
		endcase
		next_standby = (next_state == flash_pin_pkg::ST_STANDBY);
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state           <= flash_pin_pkg::ST_STANDBY;
			frame_start_out <= 1'b0;
			frame_end_out   <= 1'b0;
			standby_out     <= 1'b1;
			selected_out    <= 1'b0;
		end else begin
			state           <= next_state;
			frame_start_out <= next_frame_start;
			frame_end_out   <= next_frame_end;
			standby_out     <= next_standby;
			selected_out    <= selected;
		end
	end

	// receive path: single input lane into the byte fifo
	logic [7:0] rx_shift;
	logic [2:0] rx_cnt;
	logic [7:0] rx_byte;
	logic       rx_push;
	logic       rx_overrun;
	logic [7:0] next_rx_shift;
	logic [2:0] next_rx_cnt;
	logic [7:0] next_rx_byte;
	logic       next_rx_push;
	logic       next_rx_overrun;
	logic       fifo_in_ready;

	always_comb begin
		next_rx_shift   = rx_shift;
		next_rx_cnt     = rx_cnt;
		next_rx_byte    = rx_byte;
		next_rx_push    = 1'b0;
		next_rx_overrun = rx_overrun;
		if (cs_fall) begin
			next_rx_cnt     = `RX_FIRST_BIT;
			next_rx_overrun = 1'b0;
		end
		if (selected && !read_phase_in && sck_rise) begin
			next_rx_shift = {rx_shift[6:0], io_s[0]};
			if (cs_fall || rx_cnt == `RX_LAST_BIT) begin
				next_rx_cnt = cs_fall ? `RX_FIRST_BIT + 3'h1 : `RX_FIRST_BIT;
			end else begin
				next_rx_cnt = rx_cnt + 3'h1;
			end
			if (!cs_fall && rx_cnt == `RX_LAST_BIT) begin
				next_rx_push = 1'b1;
				next_rx_byte = {rx_shift[6:0], io_s[0]};
			end
		end
		// a lost byte wins over the start-of-frame clear
		if (rx_push && !fifo_in_ready) begin
			next_rx_overrun = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			rx_shift   <= '0;
			rx_cnt     <= `RX_FIRST_BIT;
			rx_byte    <= '0;
			rx_push    <= 1'b0;
			rx_overrun <= 1'b0;
		end else begin
			rx_shift   <= next_rx_shift;
			rx_cnt     <= next_rx_cnt;
			rx_byte    <= next_rx_byte;
			rx_push    <= next_rx_push;
			rx_overrun <= next_rx_overrun;
		end
	end

	assign rx_overrun_out = rx_overrun;

	rx_byte_fifo #(
		.WIDTH (`RX_FIFO_WIDTH),
		.DEPTH (`RX_FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (sys_clk_in),
		.rst       (rst_in),
		.in_valid  (rx_push),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_byte),
		.out_valid (rx_valid_out),
		.out_ready (rx_ready_in),
		.out_data  (rx_data_out)
	);

	// transmit path: one, two or four lanes per falling edge
	logic [7:0] tx_shift;
	logic [3:0] tx_left;
	logic [7:0] next_tx_shift;
	logic [3:0] next_tx_left;
	logic [3:0] next_io;
	logic [3:0] next_oe;
	logic [3:0] lane_bits;
	logic [3:0] lane_mask;
	logic [7:0] tx_word;
	logic       quad_ok;
	logic       tx_active;

	always_comb begin
		quad_ok   = quad_lane_enable_in;
		lane_bits = `LANE_BITS_ONE;
		lane_mask = `OE_MASK_SINGLE;
		unique case (flash_pin_pkg::lane_mode_t'(lane_mode_in))
			flash_pin_pkg::LANE_SINGLE: begin
				lane_bits = `LANE_BITS_ONE;
				lane_mask = `OE_MASK_SINGLE;
			end
			flash_pin_pkg::LANE_DUAL: begin
				lane_bits = `LANE_BITS_TWO;
				lane_mask = `OE_MASK_DUAL;
			end
			flash_pin_pkg::LANE_QUAD: begin
				lane_bits = quad_ok ? `LANE_BITS_FOUR : `LANE_BITS_ONE;
				lane_mask = quad_ok ? `OE_MASK_QUAD : `OE_MASK_SINGLE;
			end
			default: begin
				lane_bits = `LANE_BITS_ONE;
				lane_mask = `OE_MASK_SINGLE;
			end
		endcase
		tx_active     = selected && read_phase_in;
		tx_ready_out  = tx_active && sck_fall && (tx_left == `TX_EMPTY_BITS) && tx_valid_in;
		tx_word       = tx_shift;
		if (tx_left == `TX_EMPTY_BITS) begin
			tx_word = tx_valid_in ? tx_data_in : `TX_IDLE_BYTE;
		end
		next_tx_shift = tx_shift;
		next_tx_left  = tx_left;
		next_io       = io_out;
		// drivers follow selection and read phase, off while deselected
		next_oe       = tx_active ? lane_mask : `OE_MASK_NONE;
		if (!tx_active) begin
			next_tx_left = `TX_EMPTY_BITS;
		end else if (sck_fall) begin
			if (lane_bits == `LANE_BITS_FOUR) begin
				next_io       = tx_word[7:4];
				next_tx_shift = {tx_word[3:0], 4'h0};
			end else if (lane_bits == `LANE_BITS_TWO) begin
				next_io       = {2'h0, tx_word[7:6]};
				next_tx_shift = {tx_word[5:0], 2'h0};
			end else begin
				next_io       = {2'h0, tx_word[7], 1'h0};
				next_tx_shift = {tx_word[6:0], 1'h0};
			end
			next_tx_left = ((tx_left == `TX_EMPTY_BITS) ? `BYTE_BITS : tx_left) - lane_bits;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			tx_shift  <= '0;
			tx_left   <= `TX_EMPTY_BITS;
			io_out    <= `IO_IDLE_LEVELS;
			io_oe_out <= `OE_MASK_NONE;
		end else begin
			tx_shift  <= next_tx_shift;
			tx_left   <= next_tx_left;
			io_out    <= next_io;
			io_oe_out <= next_oe;
		end
	end

	// checks
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	a_frame_start_pulse: assert property (cs_fall |=> frame_start_out && !frame_end_out)
		else $error("start pulse missing after chip select fall");
	a_frame_end_pulse: assert property (cs_rise |=> frame_end_out ##1 !frame_end_out)
		else $error("end pulse wrong after chip select rise");
	a_deselect_hiz: assert property (cs_n_s && cs_n_d |=> io_oe_out == `OE_MASK_NONE)
		else $error("lane driven while deselected");
	a_deselect_no_rx: assert property (cs_n_s |=> !rx_push)
		else $error("byte accepted while deselected");
	a_rx_on_rise: assert property (rx_push |-> $past(sck_rise) && $past(selected))
		else $error("byte completed without rising clock");
	a_tx_on_fall: assert property (selected && $changed(io_out) |-> $past(sck_fall))
		else $error("lane data changed off a falling clock");
	a_dual_lanes: assert property (tx_active && lane_mode_in == flash_pin_pkg::LANE_DUAL
		|=> io_oe_out == `OE_MASK_DUAL)
		else $error("dual read not driving lanes 0 and 1");
	a_lane_one_drive: assert property (tx_active [*2] |-> io_oe_out[1])
		else $error("output lane not driving in read phase");
	a_busy_defers_standby: assert property (cs_rise && op_busy_in && state == flash_pin_pkg::ST_ACTIVE
		|=> !standby_out ##1 (!standby_out || !$past(op_busy_in)))
		else $error("standby entered while operation busy");
	a_quad_needs_enable: assert property (io_oe_out[3] || io_oe_out[2] |-> $past(quad_lane_enable_in))
		else $error("upper lanes driven without quad lane enable");

endmodule

`default_nettype wire

//--- dv/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	input  wire logic       clk_in,      // system clock
	input  wire logic [3:0] pins_in,     // resolved lane levels
	output logic            sck_out,     // serial clock
	output logic            cs_n_out,    // chip select, low active
	output logic            drv_oe_out,  // host drives lane 0
	output logic            drv_bit_out  // host lane 0 value
);
	initial begin
		sck_out = 1'h0;
		cs_n_out = 1'h1;
		drv_oe_out = 1'h0;
		drv_bit_out = 1'h0;
	end

	task automatic gap(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	task automatic set_cs(input logic lvl);
		cs_n_out = lvl;
	endtask

	// each clock phase lasts four system clocks, mode 0, msb first
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			drv_oe_out = 1'h1;
			drv_bit_out = b[i];
			gap(4);
			sck_out = 1'h1;
			gap(4);
			sck_out = 1'h0;
		end
		gap(4);
	endtask

	task automatic release_lanes();
		drv_oe_out = 1'h0;
		gap(2);
	endtask

	// every fall launches one unit; it is taken once settled
	task automatic read_units(input int n, input int lanes, output logic [7:0] b);
		b = 8'h00;
		for (int u = 0; u < n; u++) begin
			sck_out = 1'h1;
			gap(4);
			sck_out = 1'h0;
			gap(4);
			case (lanes)
				1: b = {b[6:0], pins_in[1]};
				2: b = {b[5:0], pins_in[1:0]};
				default: b = {b[3:0], pins_in};
			endcase
		end
	endtask
endmodule

`default_nettype wire

//--- dv/flash_serial_pin_front_end_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module flash_serial_pin_front_end_tb_top;
	logic       clk, rst, sck, cs_n, host_oe, host_bit;
	logic       qe, read_phase, op_busy, tx_valid, tx_ready, rx_valid, rx_ready;
	logic       overrun, f_start, f_end, sel, stby;
	logic       tog = 1'h0;
	logic [1:0] mode;
	logic [3:0] pins, io_out, io_oe;
	logic [7:0] tx_data, rx_data;
	int         errors, check_count;
	int         taken = 0;

	// undriven lanes 0 and 1 wander; lanes 2 and 3 are pulled up
	assign pins[0] = io_oe[0] ? io_out[0] : (host_oe ? host_bit : tog);
	assign pins[1] = io_oe[1] ? io_out[1] : ~tog;
	assign pins[2] = io_oe[2] ? io_out[2] : 1'h1;
	assign pins[3] = io_oe[3] ? io_out[3] : 1'h1;

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) tog <= ~tog;

	// counts read bytes handed to the shifter, one per ready pulse
	always @(posedge clk) if (tx_ready === 1'h1) taken <= taken + 1;

	spi_host_model u_host (.clk_in(clk), .pins_in(pins), .sck_out(sck), .cs_n_out(cs_n),
		.drv_oe_out(host_oe), .drv_bit_out(host_bit));

	flash_serial_pin_front_end u_dut (.sys_clk_in(clk), .rst_in(rst), .sck_in(sck), .cs_n_in(cs_n),
		.io_in(pins), .io_out(io_out), .io_oe_out(io_oe), .quad_lane_enable_in(qe),
		.lane_mode_in(mode), .read_phase_in(read_phase), .op_busy_in(op_busy),
		.tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
		.rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
		.rx_overrun_out(overrun), .frame_start_out(f_start), .frame_end_out(f_end),
		.selected_out(sel), .standby_out(stby));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: return f_start;
			1: return f_end;
			default: return rx_valid;
		endcase
	endfunction

	task automatic wait_for(input int w);
		int i;
		i = 0;
		while (pick(w) !== 1'h1 && i < 40) begin
			@(negedge clk);
			i++;
		end
		if (pick(w) !== 1'h1) begin
			errors++;
			$display("mismatch at %0t: wait %0d timed out", $time, w);
			stop_test();
		end
	endtask

	task automatic pop();
		rx_ready = 1'h1;
		cyc(1);
		rx_ready = 1'h0;
	endtask

	task automatic t_reset();
		chk(8'(io_oe), 8'h00, "lanes idle");
		chk(8'(stby), 8'h01, "standby");
		chk(8'(sel), 8'h00, "not selected");
		$display("test reset done");
	endtask

	task automatic t_write();
		u_host.send_byte(8'h5A);
		u_host.set_cs(1'h0);
		wait_for(0);
		cyc(2);
		chk(8'(sel), 8'h01, "selected");
		chk(8'(stby), 8'h00, "active while selected");
		u_host.send_byte(8'hA5);
		wait_for(2);
		chk(rx_data, 8'hA5, "rx byte");
		pop();
		cyc(3);
		chk(8'(rx_valid), 8'h00, "no byte from deselected bits");
		u_host.release_lanes();
		u_host.set_cs(1'h1);
		wait_for(1);
		cyc(1);
		chk(8'(stby), 8'h01, "standby after frame");
		$display("test write done");
	endtask

	task automatic t_fifo();
		u_host.set_cs(1'h0);
		wait_for(0);
		for (int i = 0; i < 10; i++) u_host.send_byte(8'h10 + 8'(i));
		cyc(6);
		chk(8'(overrun), 8'h01, "overrun");
		for (int i = 0; i < 9; i++) begin
			wait_for(2);
			chk(rx_data, 8'h10 + 8'(i), "fifo order");
			pop();
		end
		cyc(4);
		chk(8'(rx_valid), 8'h00, "fifo empty");
		u_host.release_lanes();
		u_host.set_cs(1'h1);
		wait_for(1);
		$display("test fifo done");
	endtask

	task automatic t_read();
		logic [7:0] got;
		int         before_taken;
		logic [1:0] md [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
		logic       qv [4] = '{1'h0, 1'h0, 1'h1, 1'h0};
		logic [3:0] om [4] = '{4'h2, 4'h3, 4'hF, 4'h2};
		logic [7:0] td [4] = '{8'h96, 8'h3C, 8'hA5, 8'h5A};
		logic       tv [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
		int         ln [4] = '{1, 2, 4, 1};
		for (int k = 0; k < 4; k++) begin
			mode = md[k];
			qe = qv[k];
			tx_data = td[k];
			tx_valid = tv[k];
			before_taken = taken;
			u_host.release_lanes();
			u_host.set_cs(1'h0);
			wait_for(0);
			read_phase = 1'h1;
			cyc(3);
			if (k == 0) chk(8'(overrun), 8'h00, "overrun cleared");
			chk(8'(io_oe), 8'(om[k]), "lane enables");
			u_host.read_units(8 / ln[k], ln[k], got);
			// no byte offered means the idle byte goes out
			chk(got, tv[k] ? td[k] : 8'hFF, "read byte");
			chk(8'(taken - before_taken), 8'(tv[k]), "bytes taken");
			// read phase still high: only the chip select rise may release the lanes
			u_host.set_cs(1'h1);
			wait_for(1);
			cyc(2);
			chk(8'(io_oe), 8'h00, "lanes released");
			read_phase = 1'h0;
		end
		$display("test read done");
	endtask

	task automatic t_midreset();
		u_host.set_cs(1'h0);
		wait_for(0);
		read_phase = 1'h1;
		cyc(3);
		chk(8'(io_oe), 8'h02, "driving before reset");
		rst = 1'h1;
		cyc(2);
		chk(8'(io_oe), 8'h00, "lanes off in reset");
		chk(8'(stby), 8'h01, "standby in reset");
		chk(8'(sel), 8'h00, "deselected in reset");
		read_phase = 1'h0;
		u_host.set_cs(1'h1);
		cyc(1);
		rst = 1'h0;
		cyc(4);
		chk(8'(f_start), 8'h00, "no start after reset");
		chk(8'(stby), 8'h01, "standby after reset");
		$display("test mid reset done");
	endtask

	task automatic t_busy();
		u_host.set_cs(1'h0);
		wait_for(0);
		op_busy = 1'h1;
		u_host.set_cs(1'h1);
		wait_for(1);
		cyc(6);
		chk(8'(stby), 8'h00, "standby held off");
		op_busy = 1'h0;
		cyc(2);
		chk(8'(stby), 8'h01, "standby after busy");
		$display("test busy done");
	endtask

	initial begin
		rst = 1'h1;
		qe = 1'h0;
		mode = 2'h0;
		read_phase = 1'h0;
		op_busy = 1'h0;
		tx_data = 8'h96;
		tx_valid = 1'h1;
		rx_ready = 1'h0;
		errors = 0;
		check_count = 0;
		repeat (3) @(negedge clk);
		rst = 1'h0;
		cyc(4);
		t_reset();
		t_write();
		t_fifo();
		t_read();
		t_busy();
		t_midreset();
		stop_test();
	end
endmodule

`default_nettype wire
